/* rtl/hcd_top.sv */
// Purpose: Hall sensor commutation decoder with AXI4-Lite control and status
// Assumes: Mode and protection pins synchronous to clk_i; hall pins asynchronous
// Notes: Drives update one edge after the synchronised code or pins change
// Function
// - Each valid code turns on one top and one bottom switch, different legs.
// - Forward codes: 60 phasing 100,110,111,011,001,000; 120 phasing 101,100,110,010,011,001.
// - 300 and 240 sequences are reversed, so they rotate the other way.
// - Phasing select high and direction high run a 60 motor forward while the control direction invert bit (bit 1) is clear.
// - Phasing select high selects 60/300 decode, low selects 120/240 decode.
// - Overtemperature forces every top and bottom drive off.
// - Codes 101,010 at 60 and 111,000 at 120 switch all drives off.
// - Enable low switches all drives off whatever the code.
// - Top drives are active low, bottom drives active high.
// - Phasing select high means 60 degree sensors, low means 120 degree.
//
// Register access over AXI4-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "hcd_map.svh"

module hcd_top (
	// Clock and reset
	input wire logic clk_i,
	input wire logic arst_n_i,
	// Rotor position sensors
	input wire logic hall_a_i,
	input wire logic hall_b_i,
	input wire logic hall_c_i,
	// Mode and protection pins
	input wire logic phase_sel_i,
	input wire logic direction_select_i,
	input wire logic enable_i,
	input wire logic overtemp_i,
	// Switch drives
	output logic [2:0] top_drive_n_o,
	output logic [2:0] bottom_drive_o,
	// AXI4-Lite write
	input wire logic [`HCD_ADDR_W-1:0] awaddr_i,
	input wire logic awvalid_i,
	output logic awready_o,
	input wire logic [31:0] wdata_i,
	input wire logic [3:0] wstrb_i,
	input wire logic wvalid_i,
	output logic wready_o,
	output logic [1:0] bresp_o,
	output logic bvalid_o,
	input wire logic bready_i,
	// AXI4-Lite read
	input wire logic [`HCD_ADDR_W-1:0] araddr_i,
	input wire logic arvalid_i,
	output logic arready_o,
	output logic [31:0] rdata_o,
	output logic [1:0] rresp_o,
	output logic rvalid_o,
	input wire logic rready_i
);

	// ==========================================================
	// Reset release
	logic rst_meta_reg;
	logic rst_n_reg;
	logic rst_n;

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rst_meta_reg <= 1'b0;
			rst_n_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n_reg <= rst_meta_reg;
		end
	end
	assign rst_n = rst_n_reg;

	// ==========================================================
	// Sensor synchroniser
	hcd_pkg::hcd_code_t hall_pins;
	hcd_pkg::hcd_code_t hall_meta_reg;
	hcd_pkg::hcd_code_t hall_sync_reg;
	hcd_pkg::hcd_code_t code_prev_reg;

	assign hall_pins = {hall_a_i, hall_b_i, hall_c_i};

	// Avoids a half-changed code decoding to a shoot-through pair
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			hall_meta_reg <= 3'h0;
			hall_sync_reg <= 3'h0;
			code_prev_reg <= 3'h0;
		end else begin
			hall_meta_reg <= hall_pins;
			hall_sync_reg <= hall_meta_reg;
			code_prev_reg <= hall_sync_reg;
		end
	end

	// ==========================================================
	// Decode and gating
	logic [1:0] ctrl_reg;
	logic [1:0] ctrl_next;
	logic run_en;
	logic dir_eff;
	logic dec_valid;
	hcd_pkg::hcd_drive_t dec_drive;
	hcd_pkg::hcd_drive_t drive_reg;
	hcd_pkg::hcd_drive_t drive_next;
	hcd_pkg::hcd_drive_t drive_off;

	assign drive_off = '{top_n: `HCD_TOP_OFF, bot: `HCD_BOT_OFF};
	assign run_en = enable_i & ctrl_reg[`HCD_CTRL_RUN_BIT] & ~overtemp_i;
	// Software inversion lets a 300/240 motor match a 60/120 one
	assign dir_eff = direction_select_i ^ ctrl_reg[`HCD_CTRL_DINV_BIT];

	hcd_decoder u_decoder (
		.code_i(hall_sync_reg),
		.phase_60_i(phase_sel_i),
		.forward_i(dir_eff),
		.drive_o(dec_drive),
		.valid_o(dec_valid)
	);

	assign drive_next = (run_en & dec_valid) ? dec_drive : drive_off;

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			drive_reg <= '{top_n: `HCD_TOP_OFF, bot: `HCD_BOT_OFF};
		end else begin
			drive_reg <= drive_next;
		end
	end

	assign top_drive_n_o = drive_reg.top_n;
	assign bottom_drive_o = drive_reg.bot;

	// ==========================================================
	// Commutation step counter
	logic [15:0] cnt_reg;
	logic step_evt;

	assign step_evt = dec_valid & (hall_sync_reg != code_prev_reg);

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= 16'h0000;
		end else if (step_evt) begin
			cnt_reg <= cnt_reg + 16'h0001;
		end
	end

	// ==========================================================
	// AXI4-Lite write path
	logic aw_rdy_reg;
	logic w_rdy_reg;
	logic aw_hold_reg;
	logic w_hold_reg;
	logic bvalid_reg;
	logic [1:0] bresp_reg;
	logic [`HCD_ADDR_W-1:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic aw_fire;
	logic w_fire;
	logic aw_have;
	logic w_have;
	logic b_issue;
	logic aw_hold_next;
	logic w_hold_next;
	logic bvalid_next;
	logic [`HCD_ADDR_W-1:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_mapped;
	logic wr_ctrl;

	assign aw_fire = awvalid_i & aw_rdy_reg;
	assign w_fire = wvalid_i & w_rdy_reg;
	assign aw_have = aw_hold_reg | aw_fire;
	assign w_have = w_hold_reg | w_fire;
	assign b_issue = aw_have & w_have;
	assign aw_hold_next = aw_have & ~b_issue;
	assign w_hold_next = w_have & ~b_issue;
	assign bvalid_next = b_issue | (bvalid_reg & ~bready_i);
	assign wr_addr = aw_fire ? awaddr_i : aw_addr_reg;
	assign wr_data = w_fire ? wdata_i : w_data_reg;
	assign wr_strb = w_fire ? wstrb_i : w_strb_reg;
	assign wr_ctrl = ({wr_addr[`HCD_ADDR_W-1:2], 2'b00} == `HCD_CTRL_OFS);
	assign wr_mapped = wr_ctrl | ({wr_addr[`HCD_ADDR_W-1:2], 2'b00} == `HCD_STAT_OFS)
		| ({wr_addr[`HCD_ADDR_W-1:2], 2'b00} == `HCD_CNT_OFS);
	assign ctrl_next = (b_issue & wr_ctrl & wr_strb[0]) ? wr_data[1:0] : ctrl_reg;

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			aw_rdy_reg <= 1'b0;
			w_rdy_reg <= 1'b0;
			aw_hold_reg <= 1'b0;
			w_hold_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= `HCD_RESP_OKAY;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
			ctrl_reg <= `HCD_CTRL_RST;
		end else begin
			aw_rdy_reg <= ~aw_hold_next & ~bvalid_next;
			w_rdy_reg <= ~w_hold_next & ~bvalid_next;
			aw_hold_reg <= aw_hold_next;
			w_hold_reg <= w_hold_next;
			bvalid_reg <= bvalid_next;
			ctrl_reg <= ctrl_next;
			if (aw_fire) begin
				aw_addr_reg <= awaddr_i;
			end
			if (w_fire) begin
				w_data_reg <= wdata_i;
				w_strb_reg <= wstrb_i;
			end
			if (b_issue) begin
				bresp_reg <= wr_mapped ? `HCD_RESP_OKAY : `HCD_RESP_SLVERR;
			end
		end
	end

	assign awready_o = aw_rdy_reg;
	assign wready_o = w_rdy_reg;
	assign bvalid_o = bvalid_reg;
	assign bresp_o = bresp_reg;

	// ==========================================================
	// AXI4-Lite read path
	logic ar_rdy_reg;
	logic rvalid_reg;
	logic rvalid_next;
	logic [31:0] rdata_reg;
	logic [1:0] rresp_reg;
	logic ar_fire;
	logic [`HCD_ADDR_W-1:0] rd_word;
	hcd_pkg::hcd_status_t status;
	logic [31:0] rd_mux;
	logic rd_mapped;

	assign ar_fire = arvalid_i & ar_rdy_reg;
	assign rvalid_next = ar_fire | (rvalid_reg & ~rready_i);
	assign rd_word = {araddr_i[`HCD_ADDR_W-1:2], 2'b00};
	assign status = '{zero: 20'h00000, bot_on: drive_reg.bot, top_on: ~drive_reg.top_n,
		enable_pin: enable_i, overtemp: overtemp_i, invalid: ~dec_valid, code: hall_sync_reg};
	assign rd_mapped = (rd_word == `HCD_CTRL_OFS) | (rd_word == `HCD_STAT_OFS) | (rd_word == `HCD_CNT_OFS);
	assign rd_mux = (rd_word == `HCD_CTRL_OFS) ? {30'h0, ctrl_reg}
		: (rd_word == `HCD_STAT_OFS) ? 32'(status)
		: (rd_word == `HCD_CNT_OFS) ? {16'h0000, cnt_reg}
		: 32'h0000_0000;

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			ar_rdy_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
			rresp_reg <= `HCD_RESP_OKAY;
		end else begin
			ar_rdy_reg <= ~rvalid_next;
			rvalid_reg <= rvalid_next;
			if (ar_fire) begin
				rdata_reg <= rd_mux;
				rresp_reg <= rd_mapped ? `HCD_RESP_OKAY : `HCD_RESP_SLVERR;
			end
		end
	end

	assign arready_o = ar_rdy_reg;
	assign rvalid_o = rvalid_reg;
	assign rdata_o = rdata_reg;
	assign rresp_o = rresp_reg;

	// ==========================================================
	// Checks
	property p_one_pair;
		@(posedge clk_i) disable iff (!rst_n)
		(run_en && dec_valid) |=> ($onehot(~top_drive_n_o) && $onehot(bottom_drive_o)
			&& ((~top_drive_n_o & bottom_drive_o) == 3'h0));
	endproperty
	a_one_pair: assert property (p_one_pair) else $error("drive pair not one top one bottom");

	property p_reverse;
		@(posedge clk_i) disable iff (!rst_n)
		(run_en && phase_sel_i && !dir_eff && hall_sync_reg == `HCD_C60_S0)
			|=> (top_drive_n_o == 3'h3 && bottom_drive_o == 3'h1);
	endproperty
	a_reverse: assert property (p_reverse) else $error("reverse step wrong");

	property p_fwd60;
		@(posedge clk_i) disable iff (!rst_n)
		(run_en && phase_sel_i && dir_eff && hall_sync_reg == `HCD_C60_S0)
			|=> (top_drive_n_o == 3'h6 && bottom_drive_o == 3'h4);
	endproperty
	a_fwd60: assert property (p_fwd60) else $error("60 forward step wrong");

	property p_fwd120;
		@(posedge clk_i) disable iff (!rst_n)
		(run_en && !phase_sel_i && dir_eff && hall_sync_reg == `HCD_C120_S3)
			|=> (top_drive_n_o == 3'h3 && bottom_drive_o == 3'h1);
	endproperty
	a_fwd120: assert property (p_fwd120) else $error("120 forward step wrong");

	property p_overtemp;
		@(posedge clk_i) disable iff (!rst_n)
		overtemp_i |=> (top_drive_n_o == `HCD_TOP_OFF && bottom_drive_o == `HCD_BOT_OFF);
	endproperty
	a_overtemp: assert property (p_overtemp) else $error("drive on during overtemperature");

	property p_invalid;
		@(posedge clk_i) disable iff (!rst_n)
		((phase_sel_i && (hall_sync_reg == 3'h5 || hall_sync_reg == 3'h2))
			|| (!phase_sel_i && (hall_sync_reg == 3'h7 || hall_sync_reg == 3'h0)))
			|=> (top_drive_n_o == `HCD_TOP_OFF && bottom_drive_o == `HCD_BOT_OFF);
	endproperty
	a_invalid: assert property (p_invalid) else $error("drive on for invalid code");

	property p_disable;
		@(posedge clk_i) disable iff (!rst_n)
		!enable_i |=> (top_drive_n_o == `HCD_TOP_OFF && bottom_drive_o == `HCD_BOT_OFF);
	endproperty
	a_disable: assert property (p_disable) else $error("drive on while disabled");

	property p_polarity;
		@(posedge clk_i) disable iff (!rst_n)
		(top_drive_n_o == `HCD_TOP_OFF) == (bottom_drive_o == `HCD_BOT_OFF);
	endproperty
	a_polarity: assert property (p_polarity) else $error("top and bottom activity disagree");

	property p_sync_depth;
		@(posedge clk_i) disable iff (!rst_n)
		$past(rst_n, 2) |-> (hall_sync_reg == $past(hall_pins, 2));
	endproperty
	a_sync_depth: assert property (p_sync_depth) else $error("sensor code not two stages late");

endmodule : hcd_top
`default_nettype wire

/* rtl/hcd_map.svh */
// Purpose: Offsets, field positions, reset values and sensor codes of the commutation decoder
// Assumes: Included by bare name; definitions only
// Notes: Codes are {hall_a, hall_b, hall_c}, hall_a in the high bit
`ifndef HCD_MAP_SVH
`define HCD_MAP_SVH

// ==========================================================
// Register map (byte addresses, one word each)
`define HCD_ADDR_W 8
`define HCD_CTRL_OFS 8'h00
`define HCD_STAT_OFS 8'h04
`define HCD_CNT_OFS 8'h08

// ==========================================================
// Control fields and reset value
`define HCD_CTRL_RUN_BIT 0
`define HCD_CTRL_DINV_BIT 1
`define HCD_CTRL_RST 2'h1

// ==========================================================
// Bus answers
`define HCD_RESP_OKAY 2'h0
`define HCD_RESP_SLVERR 2'h2

// ==========================================================
// Drive levels with every switch off
`define HCD_TOP_OFF 3'h7
`define HCD_BOT_OFF 3'h0

// ==========================================================
// Forward code sequence, 60 degree phasing
`define HCD_C60_S0 3'h4
`define HCD_C60_S1 3'h6
`define HCD_C60_S2 3'h7
`define HCD_C60_S3 3'h3
`define HCD_C60_S4 3'h1
`define HCD_C60_S5 3'h0

// ==========================================================
// Forward code sequence, 120 degree phasing, aligned so each step
// gives the same drive pair as the 60 degree code of that step
`define HCD_C120_S0 3'h4
`define HCD_C120_S1 3'h6
`define HCD_C120_S2 3'h2
`define HCD_C120_S3 3'h3
`define HCD_C120_S4 3'h1
`define HCD_C120_S5 3'h5

// ==========================================================
// Step index marking an invalid code; reverse swaps top and bottom, three steps ahead
`define HCD_STEP_BAD 3'h7
`define HCD_REV_SHIFT 3'h3

`endif

/* rtl/hcd_pkg.sv */
// Purpose: Types shared by the commutation decoder files
// Assumes: Nothing is imported; users write hcd_pkg::name
// Notes: Leg bit 0 is phase A, bit 1 phase B, bit 2 phase C
package hcd_pkg;

	typedef logic [2:0] hcd_code_t;

	// Top enables are active low, bottom enables active high
	typedef struct packed {
		logic [2:0] top_n;
		logic [2:0] bot;
	} hcd_drive_t;

	typedef struct packed {
		logic [19:0] zero;
		logic [2:0] bot_on;
		logic [2:0] top_on;
		logic enable_pin;
		logic overtemp;
		logic invalid;
		hcd_code_t code;
	} hcd_status_t;

endpackage : hcd_pkg

/* rtl/hcd_decoder.sv */
// Purpose: Rotor position code to switch enable decode
// Assumes: Code already synchronised; purely combinational
// Notes: Gating by enable and shutdown is done by the caller
`timescale 1ns/1ps
`default_nettype none
`include "hcd_map.svh"

module hcd_decoder (
	// Position and mode
	input wire hcd_pkg::hcd_code_t code_i,
	input wire logic phase_60_i,
	input wire logic forward_i,
	// Decoded drive
	output hcd_pkg::hcd_drive_t drive_o,
	output logic valid_o
);

	// ==========================================================
	// Code to forward step index
	function automatic logic [2:0] code_step(input logic [2:0] code, input logic p60);
		logic [2:0] s;
		s = `HCD_STEP_BAD;
		if (p60) begin
			unique case (code)
				`HCD_C60_S0: s = 3'h0;
				`HCD_C60_S1: s = 3'h1;
				`HCD_C60_S2: s = 3'h2;
				`HCD_C60_S3: s = 3'h3;
				`HCD_C60_S4: s = 3'h4;
				`HCD_C60_S5: s = 3'h5;
				default: s = `HCD_STEP_BAD;
			endcase
		end else begin
			unique case (code)
				`HCD_C120_S0: s = 3'h0;
				`HCD_C120_S1: s = 3'h1;
				`HCD_C120_S2: s = 3'h2;
				`HCD_C120_S3: s = 3'h3;
				`HCD_C120_S4: s = 3'h4;
				`HCD_C120_S5: s = 3'h5;
				default: s = `HCD_STEP_BAD;
			endcase
		end
		return s;
	endfunction : code_step

	logic [2:0] step;
	logic [3:0] sum;
	logic [2:0] idx;

	assign step = code_step(code_i, phase_60_i);
	assign valid_o = (step != `HCD_STEP_BAD);
	// Reverse swaps top and bottom, which is the pairing three steps on
	assign sum = {1'b0, step} + {1'b0, `HCD_REV_SHIFT};
	assign idx = forward_i ? step : ((sum >= 4'h6) ? 3'(sum - 4'h6) : sum[2:0]);

	// One top and one bottom on different legs per step
	always_comb begin
		drive_o = '{top_n: `HCD_TOP_OFF, bot: `HCD_BOT_OFF};
		unique case (idx)
			3'h0: drive_o = '{top_n: 3'h6, bot: 3'h4};
			3'h1: drive_o = '{top_n: 3'h5, bot: 3'h4};
			3'h2: drive_o = '{top_n: 3'h5, bot: 3'h1};
			3'h3: drive_o = '{top_n: 3'h3, bot: 3'h1};
			3'h4: drive_o = '{top_n: 3'h3, bot: 3'h2};
			3'h5: drive_o = '{top_n: 3'h6, bot: 3'h2};
			default: drive_o = '{top_n: `HCD_TOP_OFF, bot: `HCD_BOT_OFF};
		endcase
	end

endmodule : hcd_decoder
`default_nettype wire

/* tb/hcd_hall_model.sv */
// Purpose: Rotor position sensors for the commutation decoder bench
// Assumes: Step index is advanced by the bench at a clock edge
// Notes: conv 0=60, 1=120, 2=240, 3=300 degree phasing
`timescale 1ns/1ps
`default_nettype none

module hcd_hall_model (
	// Position and convention
	input wire logic [1:0] conv_i,
	input wire logic [2:0] pos_i,
	// Faulty sensor code on command
	input wire logic bad_i,
	input wire hcd_pkg::hcd_code_t bad_code_i,
	// Sensor levels {a,b,c}
	output hcd_pkg::hcd_code_t code_o
);
	// ==========================================================
	// Six codes per revolution, step 0 in the low bits
	localparam logic [17:0] SEQ60 = {3'h0, 3'h1, 3'h3, 3'h7, 3'h6, 3'h4};
	localparam logic [17:0] SEQ120 = {3'h5, 3'h1, 3'h3, 3'h2, 3'h6, 3'h4};
	wire logic [2:0] rev_idx = (pos_i == 3'h0) ? 3'h0 : 3'h6 - pos_i;
	wire logic [2:0] idx = conv_i[1] ? rev_idx : pos_i;
	wire logic [17:0] seq = (conv_i == 2'h0 || conv_i == 2'h3) ? SEQ60 : SEQ120;
	assign code_o = bad_i ? bad_code_i : seq[3*idx +: 3];
endmodule : hcd_hall_model

`default_nettype wire

/* tb/testbench.sv */
// Purpose: Self-checking bench for the commutation decoder
// Assumes: Drives settle 3 edges after a hall change, 1 edge after a pin or control change
// Notes: Drive pairs worked out from the forward step table
`timescale 1ns/1ps
`default_nettype none
`include "hcd_map.svh"

module testbench;
	logic clk_i, arst_n_i, phase_sel_i, direction_select_i, enable_i, overtemp_i;
	logic [7:0] awaddr_i, araddr_i;
	logic awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i;
	logic [31:0] wdata_i;
	logic [3:0] wstrb_i;
	logic [1:0] conv;
	logic [2:0] pos;
	logic bad;
	hcd_pkg::hcd_code_t bad_code, hall;
	wire logic [2:0] top_drive_n_o, bottom_drive_o;
	wire logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o;
	wire logic [1:0] bresp_o, rresp_o;
	wire logic [31:0] rdata_o;
	int fail_count, num_checks;
	int top_leg[6] = '{0, 1, 1, 2, 2, 0};
	int bot_leg[6] = '{2, 2, 0, 0, 1, 1};
	logic [31:0] rd;
	logic [1:0] rs;

	hcd_hall_model u_hcd_hall_model (.conv_i(conv), .pos_i(pos), .bad_i(bad), .bad_code_i(bad_code),
		.code_o(hall));
	hcd_top u_hcd_top (.clk_i(clk_i), .arst_n_i(arst_n_i), .hall_a_i(hall[2]), .hall_b_i(hall[1]),
		.hall_c_i(hall[0]), .phase_sel_i(phase_sel_i), .direction_select_i(direction_select_i),
		.enable_i(enable_i), .overtemp_i(overtemp_i), .top_drive_n_o(top_drive_n_o),
		.bottom_drive_o(bottom_drive_o), .awaddr_i(awaddr_i), .awvalid_i(awvalid_i),
		.awready_o(awready_o), .wdata_i(wdata_i), .wstrb_i(wstrb_i), .wvalid_i(wvalid_i),
		.wready_o(wready_o), .bresp_o(bresp_o), .bvalid_o(bvalid_o), .bready_i(bready_i),
		.araddr_i(araddr_i), .arvalid_i(arvalid_i), .arready_o(arready_o), .rdata_o(rdata_o),
		.rresp_o(rresp_o), .rvalid_o(rvalid_o), .rready_i(rready_i));

	// ==========================================================
	// Checking and closing
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask : chk

	task automatic stop_test;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : stop_test

	function automatic logic [31:0] exp_drv(int c, int d, int p, int inv);
		int i;
		i = (c >= 2) ? (6 - p) % 6 : p;
		if ((d ^ inv) == 0) i = (i + 3) % 6;
		return {26'h0, ~(3'h1 << top_leg[i]), 3'h1 << bot_leg[i]};
	endfunction : exp_drv

	function automatic logic [31:0] drv();
		return {26'h0, top_drive_n_o, bottom_drive_o};
	endfunction : drv

	// ==========================================================
	// AXI4-Lite master: request held until its own ready edge
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
		int n;
		logic done;
		@(posedge clk_i);
		awaddr_i <= a;
		wdata_i <= d;
		wstrb_i <= s;
		awvalid_i <= 1'b1;
		wvalid_i <= 1'b1;
		bready_i <= 1'b1;
		done = 1'b0;
		n = 0;
		while (!done && n < 64) begin
			@(posedge clk_i);
			n++;
			if (awvalid_i && awready_o) awvalid_i <= 1'b0;
			if (wvalid_i && wready_o) wvalid_i <= 1'b0;
			if (bvalid_o === 1'b1) begin
				r = bresp_o;
				bready_i <= 1'b0;
				done = 1'b1;
			end
		end
		chk({31'h0, done}, 32'h1, "write answer");
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		logic done;
		@(posedge clk_i);
		araddr_i <= a;
		arvalid_i <= 1'b1;
		rready_i <= 1'b1;
		done = 1'b0;
		n = 0;
		while (!done && n < 64) begin
			@(posedge clk_i);
			n++;
			if (arvalid_i && arready_o) arvalid_i <= 1'b0;
			if (rvalid_o === 1'b1) begin
				d = rdata_o;
				r = rresp_o;
				rready_i <= 1'b0;
				done = 1'b1;
			end
		end
		chk({31'h0, done}, 32'h1, "read answer");
	endtask : axi_rd

	// ==========================================================
	// Scenarios
	task automatic t_regs;
		axi_rd(`HCD_CTRL_OFS, rd, rs);
		chk(rd, 32'h1, "ctrl reset");
		axi_wr(8'h20, 32'h0, 4'hF, rs);
		chk({30'h0, rs}, 32'h2, "unmapped write");
		axi_rd(8'h20, rd, rs);
		chk({rs, rd[29:0]}, 32'h80000000, "unmapped read");
		axi_wr(`HCD_STAT_OFS, 32'hFFF, 4'hF, rs);
		axi_rd(`HCD_STAT_OFS, rd, rs);
		chk(rd, {20'h0, 3'h4, 3'h1, 1'b1, 1'b0, 1'b0, 3'h4}, "status");
	endtask : t_regs

	task automatic t_sweep;
		for (int c = 0; c < 4; c++) begin
			for (int d = 0; d < 2; d++) begin
				for (int p = 0; p < 6; p++) begin
					@(posedge clk_i);
					conv <= c[1:0];
					pos <= p[2:0];
					direction_select_i <= d[0];
					phase_sel_i <= (c == 0 || c == 3);
					repeat (4) @(posedge clk_i);
					chk(drv(), exp_drv(c, d, p, 0), "sweep");
				end
			end
		end
	endtask : t_sweep

	task automatic t_invalid;
		logic [2:0] codes[4] = '{3'h5, 3'h2, 3'h7, 3'h0};
		for (int i = 0; i < 4; i++) begin
			@(posedge clk_i);
			phase_sel_i <= (i < 2);
			bad <= 1'b1;
			bad_code <= codes[i];
			repeat (4) @(posedge clk_i);
			chk(drv(), 32'h38, "invalid code");
		end
		@(posedge clk_i);
		bad <= 1'b0;
		phase_sel_i <= 1'b1;
		conv <= 2'h0;
		pos <= 3'h0;
		direction_select_i <= 1'b1;
	endtask : t_invalid

	task automatic t_gate;
		for (int g = 0; g < 2; g++) begin
			@(posedge clk_i);
			enable_i <= (g != 0);
			overtemp_i <= (g == 1);
			repeat (4) @(posedge clk_i);
			chk(drv(), 32'h38, "gated");
		end
		@(posedge clk_i);
		overtemp_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		chk(drv(), exp_drv(0, 1, 0, 0), "ungated");
		axi_wr(`HCD_CTRL_OFS, 32'h0, 4'hF, rs);
		repeat (4) @(posedge clk_i);
		chk(drv(), 32'h38, "run off");
		axi_wr(`HCD_CTRL_OFS, 32'h3, 4'hF, rs);
		repeat (4) @(posedge clk_i);
		chk(drv(), exp_drv(0, 1, 0, 1), "dir invert");
		axi_wr(`HCD_CTRL_OFS, 32'h1, 4'h0, rs);
		axi_rd(`HCD_CTRL_OFS, rd, rs);
		chk(rd, 32'h3, "strobe off");
		axi_wr(`HCD_CTRL_OFS, 32'h1, 4'hF, rs);
	endtask : t_gate

	task automatic t_sync;
		repeat (4) @(posedge clk_i);
		pos <= 3'h1;
		// Old pair must survive two edges of synchroniser delay
		repeat (2) @(posedge clk_i);
		#1;
		chk(drv(), exp_drv(0, 1, 0, 0), "sync hold");
		@(posedge clk_i);
		#1;
		chk(drv(), exp_drv(0, 1, 1, 0), "sync pass");
	endtask : t_sync

	// ==========================================================
	// Clock, watchdog, main sequence
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	initial begin
		repeat (20000) @(posedge clk_i);
		fail_count++;
		$display("wrong value at %0t: run did not finish", $time);
		stop_test();
	end

	initial begin
		arst_n_i <= 1'b0;
		{phase_sel_i, direction_select_i, enable_i, overtemp_i} <= 4'hE;
		{awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i} <= 5'h0;
		{awaddr_i, araddr_i, wdata_i, wstrb_i} <= 52'h0;
		{conv, pos, bad, bad_code} <= 9'h0;
		fail_count = 0;
		num_checks = 0;
		repeat (16) @(posedge clk_i);
		chk(drv(), 32'h38, "in reset");
		arst_n_i <= 1'b1;
		repeat (6) @(posedge clk_i);
		t_regs();
		t_sweep();
		t_invalid();
		t_gate();
		t_sync();
		stop_test();
	end
endmodule : testbench

`default_nettype wire
